/* core/irq_winner_flag_and_index.sv */
// winner flag and winner index registers of a two-group interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_winner_defines.svh"

module irq_winner_flag_and_index #(
    parameter int unsigned SRC_W = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // group one request state and arbiter winner
    input wire logic [SRC_W-1:0] raw_latch_one,
    input wire logic [SRC_W-1:0] service_block_one,
    input wire logic [SRC_W-1:0] path_select_one,
    input wire logic arb_valid_one,
    input wire logic [$clog2(SRC_W)-1:0] arb_index_one,
    // group two request state and arbiter winner
    input wire logic [SRC_W-1:0] raw_latch_two,
    input wire logic [SRC_W-1:0] service_block_two,
    input wire logic [SRC_W-1:0] path_select_two,
    input wire logic arb_valid_two,
    input wire logic [$clog2(SRC_W)-1:0] arb_index_two,
    // processor side
    output logic irq_normal,
    output logic event_irq
);

    localparam int unsigned IDX_W = $clog2(SRC_W);

    typedef logic [SRC_W-1:0] vec_t;
    typedef logic [IDX_W-1:0] idx_t;

    vec_t raw [2];
    vec_t blk [2];
    vec_t mode [2];
    vec_t legal [2];
    logic arb_v [2];
    idx_t arb_i [2];

    vec_t flags_r [2];
    vec_t flags_nxt [2];
    idx_t index_r [2];
    idx_t index_nxt [2];
    vec_t set_vec [2];
    vec_t clr_vec [2];
    logic hazard [2];
    logic [`EVT_W-1:0] evt_r;
    logic [`EVT_W-1:0] evt_nxt;
    logic [`EVT_W-1:0] en_r;
    logic [31:0] rdata_r;
    logic irq_normal_r;
    logic event_irq_r;
    irq_winner_pkg::reg_sel_e sel;

    assign raw[0] = raw_latch_one;
    assign raw[1] = raw_latch_two;
    assign blk[0] = service_block_one;
    assign blk[1] = service_block_two;
    assign mode[0] = path_select_one;
    assign mode[1] = path_select_two;
    assign legal[0] = SRC_W'(`LEGAL_ONE); // RL9
    assign legal[1] = SRC_W'(`LEGAL_TWO); // RL10
    assign arb_v[0] = arb_valid_one;
    assign arb_v[1] = arb_valid_two;
    assign arb_i[0] = arb_index_one;
    assign arb_i[1] = arb_index_two;

    // address decode; index registers have no write path
    function automatic irq_winner_pkg::reg_sel_e decode(input logic [31:0] a);
        case (a)
            `FLAGS_ONE_ADDR: decode = irq_winner_pkg::SEL_FLAGS_ONE;
            `INDEX_ONE_ADDR: decode = irq_winner_pkg::SEL_INDEX_ONE; // RL13
            `FLAGS_TWO_ADDR: decode = irq_winner_pkg::SEL_FLAGS_TWO;
            `INDEX_TWO_ADDR: decode = irq_winner_pkg::SEL_INDEX_TWO;
            `EVT_STATUS_ADDR: decode = irq_winner_pkg::SEL_EVT_STATUS;
            `EVT_ENABLE_ADDR: decode = irq_winner_pkg::SEL_EVT_ENABLE;
            default: decode = irq_winner_pkg::SEL_NONE;
        endcase
    endfunction : decode

    // arbiter winner is accepted only for a live, unblocked, normal-path source
    function automatic logic win_ok(
        input logic v,
        input idx_t i,
        input vec_t r,
        input vec_t b,
        input vec_t m,
        input vec_t l,
        input vec_t f
    );
        win_ok = v && (f == '0) && r[i] && !b[i] && !m[i] && l[i]; // RL6 RL15 RL16 RL17 RL18
    endfunction : win_ok

    function automatic vec_t one_hot(input idx_t i);
        one_hot = vec_t'(1) << i;
    endfunction : one_hot

    assign sel = decode(reg_addr);

    always_comb begin
        for (int g = 0; g < 2; g++) begin
            if (win_ok(arb_v[g], arb_i[g], raw[g], blk[g], mode[g], legal[g], flags_r[g])) begin
                set_vec[g] = one_hot(arb_i[g]);
            end else begin
                set_vec[g] = '0;
            end
            clr_vec[g] = '0;
            hazard[g] = 1'b0;
        end
        if (reg_wr && sel == irq_winner_pkg::SEL_FLAGS_ONE) begin
            clr_vec[0] = reg_wdata[SRC_W-1:0]; // RL5
            hazard[0] = |(flags_r[0] & ~reg_wdata[SRC_W-1:0]); // RL7 RL8
        end
        if (reg_wr && sel == irq_winner_pkg::SEL_FLAGS_TWO) begin
            clr_vec[1] = reg_wdata[SRC_W-1:0]; // RL5
            hazard[1] = |(flags_r[1] & ~reg_wdata[SRC_W-1:0]); // RL7 RL8
        end
    end

    always_comb begin
        for (int g = 0; g < 2; g++) begin
            // a new winner beats a clear in the same cycle
            flags_nxt[g] = (flags_r[g] & ~clr_vec[g]) | set_vec[g]; // RL1 RL2 RL5
            if (set_vec[g] != '0) begin
                index_nxt[g] = arb_i[g]; // RL11 RL14
            end else if (flags_nxt[g] == '0 && !raw[g][index_r[g]]) begin
                index_nxt[g] = '0; // RL12
            end else begin
                index_nxt[g] = index_r[g]; // RL4
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int g = 0; g < 2; g++) begin
                flags_r[g] <= SRC_W'(`FLAGS_RESET);
                index_r[g] <= IDX_W'(`INDEX_RESET); // RL13
            end
        end else begin
            for (int g = 0; g < 2; g++) begin
                flags_r[g] <= flags_nxt[g];
                index_r[g] <= index_nxt[g];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_normal_r <= 1'b0;
        end else begin
            irq_normal_r <= (|flags_nxt[0]) || (|flags_nxt[1]); // RL2 RL19
        end
    end

    // event status: hardware set wins over a software clear
    always_comb begin
        evt_nxt = evt_r;
        if (reg_wr && sel == irq_winner_pkg::SEL_EVT_STATUS) begin
            evt_nxt = evt_nxt & ~reg_wdata[`EVT_W-1:0];
        end
        if (set_vec[0] != '0) begin
            evt_nxt[`EVT_WIN_ONE_BIT] = 1'b1;
        end
        if (set_vec[1] != '0) begin
            evt_nxt[`EVT_WIN_TWO_BIT] = 1'b1;
        end
        if (hazard[0] || hazard[1]) begin
            evt_nxt[`EVT_HAZARD_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evt_r <= `EVT_RESET;
            en_r <= `EVT_ENABLE_RESET;
            event_irq_r <= 1'b0;
        end else begin
            evt_r <= evt_nxt;
            if (reg_wr && sel == irq_winner_pkg::SEL_EVT_ENABLE) begin
                en_r <= reg_wdata[`EVT_W-1:0];
            end
            event_irq_r <= |(evt_r & en_r);
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (sel)
                irq_winner_pkg::SEL_FLAGS_ONE: rdata_r <= 32'(flags_r[0]); // RL3
                irq_winner_pkg::SEL_INDEX_ONE: rdata_r <= 32'(index_r[0]); // RL11
                irq_winner_pkg::SEL_FLAGS_TWO: rdata_r <= 32'(flags_r[1]); // RL3
                irq_winner_pkg::SEL_INDEX_TWO: rdata_r <= 32'(index_r[1]); // RL14
                irq_winner_pkg::SEL_EVT_STATUS: rdata_r <= 32'(evt_r);
                irq_winner_pkg::SEL_EVT_ENABLE: rdata_r <= 32'(en_r);
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq_normal = irq_normal_r;
    assign event_irq = event_irq_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_flags_one_read;
        reg_rd && reg_addr == `FLAGS_ONE_ADDR;
    endsequence

    sequence s_write_back_one;
        reg_wr && reg_addr == `FLAGS_ONE_ADDR && flags_r[0] != '0
            && reg_wdata[SRC_W-1:0] == flags_r[0];
    endsequence

    sequence s_zero_write_one;
        reg_wr && reg_addr == `FLAGS_ONE_ADDR && reg_wdata == 32'h0000_0000;
    endsequence

    chk_flag_one_hot: assert property ( // RL2
        $onehot0(flags_r[0]) && $onehot0(flags_r[1]))
        else $error("more than one winner flag set");

    chk_fast_no_flag: assert property ( // RL6
        arb_valid_one && path_select_one[arb_index_one] && flags_r[0] == '0
        |=> flags_r[0] == '0 && (index_r[0] == $past(index_r[0]) || index_r[0] == '0))
        else $error("fast request set a flag");

    chk_block_no_flag: assert property ( // RL17
        arb_valid_two && service_block_two[arb_index_two] && flags_r[1] == '0
        |=> flags_r[1] == '0)
        else $error("blocked request set a flag");

    chk_win_sets_index: assert property ( // RL11
        win_ok(arb_valid_one, arb_index_one, raw_latch_one, service_block_one,
            path_select_one, legal[0], flags_r[0])
        |=> flags_r[0] == one_hot($past(arb_index_one))
            && index_r[0] == $past(arb_index_one) && irq_normal)
        else $error("winner not recorded");

    chk_hold_while_set: assert property ( // RL18
        flags_r[1] != '0 && !(reg_wr && reg_addr == `FLAGS_TWO_ADDR)
        |=> flags_r[1] == $past(flags_r[1]) && index_r[1] == $past(index_r[1]))
        else $error("winner replaced while flag set");

    chk_write_back_clears: assert property ( // RL5
        s_write_back_one |=> flags_r[0] == '0)
        else $error("write-back did not clear flag");

    chk_zero_keeps_flag: assert property ( // RL5
        s_zero_write_one ##0 flags_r[0] != '0 |=> flags_r[0] == $past(flags_r[0]))
        else $error("zero write changed flag");

    chk_irq_tracks_flags: assert property ( // RL19
        irq_normal == ((|flags_r[0]) || (|flags_r[1])))
        else $error("normal irq does not track flags");

    chk_index_auto_clear: assert property ( // RL12
        flags_r[0] == '0 && !raw_latch_one[index_r[0]] && set_vec[0] == '0
        |=> index_r[0] == '0)
        else $error("index did not clear");

    chk_flags_readback: assert property ( // RL3
        s_flags_one_read |=> reg_rdata == 32'($past(flags_r[0])) ##1 reg_rdata == 32'h0000_0000
            || $past(reg_rd))
        else $error("flag read returned wrong value");

    chk_reserved_clear: assert property ( // RL9
        (flags_r[0] & ~legal[0]) == '0 && (flags_r[1] & ~legal[1]) == '0)
        else $error("reserved flag bit set");

    chk_index_read_only: assert property ( // RL13
        reg_wr && reg_addr == `INDEX_ONE_ADDR && flags_r[0] != '0
        |=> index_r[0] == $past(index_r[0]))
        else $error("index changed by write");

    chk_fast_no_flag_two: assert property ( // RL6
        arb_valid_two && path_select_two[arb_index_two] && flags_r[1] == '0
        |=> flags_r[1] == '0)
        else $error("fast request set a group two flag");

    chk_block_no_flag_one: assert property ( // RL17
        arb_valid_one && service_block_one[arb_index_one] && flags_r[0] == '0
        |=> flags_r[0] == '0)
        else $error("blocked request set a group one flag");

    chk_win_sets_index_two: assert property ( // RL14
        win_ok(arb_valid_two, arb_index_two, raw_latch_two, service_block_two,
            path_select_two, legal[1], flags_r[1])
        |=> flags_r[1] == one_hot($past(arb_index_two))
            && index_r[1] == $past(arb_index_two) && irq_normal)
        else $error("group two winner not recorded");

    chk_hold_while_set_one: assert property ( // RL18
        flags_r[0] != '0 && !(reg_wr && reg_addr == `FLAGS_ONE_ADDR)
        |=> flags_r[0] == $past(flags_r[0]) && index_r[0] == $past(index_r[0]))
        else $error("group one winner replaced while flag set");

    chk_index_clear_two: assert property ( // RL12
        flags_r[1] == '0 && !raw_latch_two[index_r[1]] && set_vec[1] == '0
        |=> index_r[1] == '0)
        else $error("group two index did not clear");

    chk_write_back_two: assert property ( // RL5
        reg_wr && reg_addr == `FLAGS_TWO_ADDR && flags_r[1] != '0
            && reg_wdata[SRC_W-1:0] == flags_r[1]
        |=> flags_r[1] == '0)
        else $error("group two write-back did not clear flag");

    chk_zero_keeps_two: assert property ( // RL5
        reg_wr && reg_addr == `FLAGS_TWO_ADDR && reg_wdata == 32'h0000_0000
            && flags_r[1] != '0
        |=> flags_r[1] == $past(flags_r[1]))
        else $error("zero write changed group two flag");

    chk_read_idle_zero: assert property ( // RL3
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside a read cycle");

    chk_hazard_event: assert property ( // RL7
        reg_wr && reg_addr == `FLAGS_TWO_ADDR
            && (flags_r[1] & ~reg_wdata[SRC_W-1:0]) != '0
        |=> evt_r[`EVT_HAZARD_BIT])
        else $error("zero write on a set flag not reported");

    chk_index_legal: assert property ( // RL9 RL14
        legal[0][index_r[0]] && legal[1][index_r[1]])
        else $error("index names a reserved source");

endmodule : irq_winner_flag_and_index
`default_nettype wire

/* core/irq_winner_defines.svh */
// register map, reset values and source layout of the winner flag and index stage
// Functional notes
// [RL1] each group holds a 32-bit winner flag register
// [RL2] at most one flag set; it drives normal irq
// [RL3] flag register readable to identify serviced source
// [RL4] software clears flag after clearing raw latch
// [RL5] writing one clears a flag; zero keeps
// [RL6] fast-mode requests never set a flag
// [RL7] software never writes zero onto set flag
// [RL8] clear a flag by writing back its value
// [RL9] group one bits 29, 19, 6 reserved
// [RL10] group two bits 3, 2 reserved
// [RL11] index returns bit number of current winner
// [RL12] index clears once latch and flag clear
// [RL13] group one index read-only, resets zero
// [RL14] group two index values per source bit
// [RL15] fast-mode requests leave index unchanged
// [RL16] path select zero normal, one fast
// [RL17] blocked sources never win a flag
// [RL18] winner taken only while group flags empty
// [RL19] normal irq high while any flag set
`ifndef IRQ_WINNER_DEFINES_SVH
`define IRQ_WINNER_DEFINES_SVH

`define FLAGS_ONE_ADDR 32'h4A00_0010
`define INDEX_ONE_ADDR 32'h4A00_0014
`define FLAGS_TWO_ADDR 32'h4A00_0050
`define INDEX_TWO_ADDR 32'h4A00_0054
`define EVT_STATUS_ADDR 32'h4A00_0060
`define EVT_ENABLE_ADDR 32'h4A00_0064

`define FLAGS_RESET 32'h0000_0000
`define INDEX_RESET 32'h0000_0000
`define EVT_RESET 3'h0
`define EVT_ENABLE_RESET 3'h0

// sources that exist; the rest are reserved and never set
`define LEGAL_ONE 32'hDFF7_FFBF
`define LEGAL_TWO 32'h0000_00F3

`define EVT_WIN_ONE_BIT 0
`define EVT_WIN_TWO_BIT 1
`define EVT_HAZARD_BIT 2
`define EVT_W 3

`endif

/* core/irq_winner_pkg.sv */
// types shared by the winner flag and index stage
package irq_winner_pkg;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_FLAGS_ONE = 3'b001,
        SEL_INDEX_ONE = 3'b010,
        SEL_FLAGS_TWO = 3'b011,
        SEL_INDEX_TWO = 3'b100,
        SEL_EVT_STATUS = 3'b101,
        SEL_EVT_ENABLE = 3'b110
    } reg_sel_e;

endpackage : irq_winner_pkg

/* test/irq_source_model.sv */
// arbiter-side model offering the top raised request as the group winner
`timescale 1ns/1ps
`default_nettype none

module irq_source_model (
    // raw requests of one group
    input wire logic [31:0] raw,
    // winner offer
    output logic valid,
    output logic [4:0] index
);
    // no filtering of mask, path or reserved bits, so the stage must refuse those itself;
    // the offer stays on its raw bit until that bit drops or a higher raw bit is raised
    always_comb begin
        valid = 1'b0;
        index = 5'h0;
        for (int k = 0; k < 32; k++) begin
            if (raw[k]) begin
                valid = 1'b1;
                index = k[4:0];
            end
        end
    end
endmodule : irq_source_model

`default_nettype wire

/* test/irq_winner_flag_and_index_tb_top.sv */
// self-checking bench of the winner flag and index stage
`timescale 1ns/1ps
`default_nettype none
`include "irq_winner_defines.svh"

module irq_winner_flag_and_index_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] raw_one = 32'h0, blk_one = 32'h0, path_one = 32'h0;
    logic [31:0] raw_two = 32'h0, blk_two = 32'h0, path_two = 32'h0;
    logic av_one, av_two, irq_normal, event_irq;
    logic [4:0] ai_one, ai_two;
    logic [31:0] d;
    int failures = 0;
    int checked = 0;
    logic [31:0] map [7] = '{`FLAGS_ONE_ADDR, `INDEX_ONE_ADDR, `FLAGS_TWO_ADDR,
        `INDEX_TWO_ADDR, `EVT_STATUS_ADDR, `EVT_ENABLE_ADDR, 32'h4A00_0070};
    int hi [2] = '{31, 5};
    int lo [2] = '{0, 1};
    int g2 [6] = '{7, 6, 5, 4, 1, 0};
    logic [31:0] rw1 [5] = '{32'h2000_0000, 32'h0008_0000, 32'h0000_0040, 32'h10, 32'h10};
    logic [31:0] rw2 [5] = '{32'h0000_0008, 32'h0000_0004, 32'h0000_0100, 32'h10, 32'h10};
    logic [31:0] bk [5] = '{32'h0, 32'h0, 32'h0, 32'h10, 32'h0};
    logic [31:0] pt [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h10};

    irq_winner_flag_and_index u_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .raw_latch_one(raw_one), .service_block_one(blk_one), .path_select_one(path_one),
        .arb_valid_one(av_one), .arb_index_one(ai_one),
        .raw_latch_two(raw_two), .service_block_two(blk_two), .path_select_two(path_two),
        .arb_valid_two(av_two), .arb_index_two(ai_two),
        .irq_normal(irq_normal), .event_irq(event_irq)
    );
    irq_source_model u_arb_one (.raw(raw_one), .valid(av_one), .index(ai_one));
    irq_source_model u_arb_two (.raw(raw_two), .valid(av_two), .index(ai_two));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        chk(n, e, d);
    endtask : rchk

    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #100000;
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (map[k]) rchk("reset value", map[k], 32'h0);
        wr(`INDEX_ONE_ADDR, 32'hFFFF_FFFF);
        wr(32'h4A00_0070, 32'hFFFF_FFFF);
        rchk("index1 read-only", `INDEX_ONE_ADDR, 32'h0);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            raw_one <= 32'h1 << hi[k];
            settle();
            chk("irq_normal set", 32'h1, irq_normal);
            rchk("flags1", `FLAGS_ONE_ADDR, 32'h1 << hi[k]);
            rchk("index1", `INDEX_ONE_ADDR, hi[k]);
            @(posedge sys_clk);
            raw_one <= (32'h1 << hi[k]) | (32'h1 << lo[k]);
            settle();
            rchk("flags1 held", `FLAGS_ONE_ADDR, 32'h1 << hi[k]);
            @(posedge sys_clk);
            raw_one <= 32'h1 << lo[k];
            rchk("flags1 before clear", `FLAGS_ONE_ADDR, 32'h1 << hi[k]);
            wr(`FLAGS_ONE_ADDR, d);
            settle();
            rchk("flags1 next", `FLAGS_ONE_ADDR, 32'h1 << lo[k]);
            rchk("index1 next", `INDEX_ONE_ADDR, lo[k]);
            @(posedge sys_clk);
            raw_one <= 32'h0;
            rchk("flags1 again", `FLAGS_ONE_ADDR, 32'h1 << lo[k]);
            wr(`FLAGS_ONE_ADDR, d);
            settle();
            chk("irq_normal clear", 32'h0, irq_normal);
            rchk("index1 auto clear", `INDEX_ONE_ADDR, 32'h0);
        end
        for (int k = 0; k < 5; k++) begin
            @(posedge sys_clk);
            raw_one <= rw1[k];
            raw_two <= rw2[k];
            {blk_one, blk_two, path_one, path_two} <= {bk[k], bk[k], pt[k], pt[k]};
            settle();
            rchk("flags1 refused", `FLAGS_ONE_ADDR, 32'h0);
            rchk("flags2 refused", `FLAGS_TWO_ADDR, 32'h0);
            rchk("index1 kept", `INDEX_ONE_ADDR, 32'h0);
            chk("irq_normal idle", 32'h0, irq_normal);
        end
        @(posedge sys_clk);
        {raw_one, raw_two, blk_one, blk_two, path_one, path_two} <= {32'h20, {5{32'h0}}};
        settle();
        wr(`FLAGS_ONE_ADDR, 32'h0);
        wr(`INDEX_ONE_ADDR, 32'hFFFF_FFFF);
        rchk("flags1 zero write", `FLAGS_ONE_ADDR, 32'h20);
        rchk("index1 write ignored", `INDEX_ONE_ADDR, 32'h5);
        @(posedge sys_clk);
        blk_one <= 32'h20;
        rchk("flags1 before clear", `FLAGS_ONE_ADDR, 32'h20);
        wr(`FLAGS_ONE_ADDR, d);
        @(posedge sys_clk);
        {raw_one, path_one} <= {32'hA0, 32'h80};
        settle();
        rchk("flags1 fast refused", `FLAGS_ONE_ADDR, 32'h0);
        rchk("index1 held", `INDEX_ONE_ADDR, 32'h5);
        @(posedge sys_clk);
        {raw_one, blk_one, path_one} <= {3{32'h0}};
        settle();
        rchk("index1 cleared", `INDEX_ONE_ADDR, 32'h0);
        @(posedge sys_clk);
        {raw_one, raw_two, blk_one, blk_two, path_one, path_two} <= {6{32'h0}};
        wr(`EVT_STATUS_ADDR, 32'h7);
        wr(`EVT_ENABLE_ADDR, 32'h2);
        rchk("event enable", `EVT_ENABLE_ADDR, 32'h2);
        for (int k = 0; k < 6; k++) begin
            @(posedge sys_clk);
            raw_two <= 32'h1 << g2[k];
            settle();
            rchk("flags2", `FLAGS_TWO_ADDR, 32'h1 << g2[k]);
            rchk("index2", `INDEX_TWO_ADDR, g2[k]);
            rchk("event status", `EVT_STATUS_ADDR, 32'h2);
            chk("event_irq raised", 32'h1, event_irq);
            @(posedge sys_clk);
            raw_two <= 32'h0;
            rchk("flags2 before clear", `FLAGS_TWO_ADDR, 32'h1 << g2[k]);
            wr(`FLAGS_TWO_ADDR, d);
            wr(`EVT_STATUS_ADDR, 32'h2);
            settle();
            chk("event_irq cleared", 32'h0, event_irq);
            rchk("index2 auto clear", `INDEX_TWO_ADDR, 32'h0);
        end
        @(posedge sys_clk);
        raw_two <= 32'h1;
        wr(`EVT_ENABLE_ADDR, 32'h0);
        settle();
        chk("event_irq masked", 32'h0, event_irq);
        @(posedge sys_clk);
        raw_two <= 32'h0;
        wr(`FLAGS_TWO_ADDR, 32'h0);
        rchk("flags2 zero write", `FLAGS_TWO_ADDR, 32'h1);
        rchk("hazard status", `EVT_STATUS_ADDR, 32'h6);
        wr(`EVT_ENABLE_ADDR, 32'h4);
        settle();
        chk("event_irq hazard", 32'h1, event_irq);
        wr(`EVT_STATUS_ADDR, 32'h6);
        wr(`FLAGS_TWO_ADDR, 32'h1);
        settle();
        chk("event_irq final", 32'h0, event_irq);
        chk("irq_normal final", 32'h0, irq_normal);
        rchk("flags2 final", `FLAGS_TWO_ADDR, 32'h0);
        @(posedge sys_clk);
        raw_one <= 32'h8000_0000;
        settle();
        chk("irq_normal before reset", 32'h1, irq_normal);
        @(posedge sys_clk);
        {rst, raw_one} <= {1'b1, 32'h0};
        @(posedge sys_clk);
        rst <= 1'b0;
        rchk("index1 after reset", `INDEX_ONE_ADDR, 32'h0);
        rchk("flags1 after reset", `FLAGS_ONE_ADDR, 32'h0);
        chk("irq_normal after reset", 32'h0, irq_normal);
        report_and_stop();
    end
endmodule : irq_winner_flag_and_index_tb_top

`default_nettype wire
